// >>> hdl/uqs_pkg.sv
package uqs_pkg;

	// Bus and channel shape
	localparam int NUM_CH = 4;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 3;

	// FIFO shape
	localparam int FIFO_DEPTH = 32;
	localparam int FIFO_PTR_W = 5;
	localparam int FIFO_CNT_W = 6;
	localparam logic [5:0] FIFO_FULL_COUNT = 6'h20;

	// Register locations inside one channel
	localparam logic [2:0] REG_DATA = 3'h0;
	localparam logic [2:0] REG_IER = 3'h1;
	localparam logic [2:0] REG_FCR_ISR = 3'h2;
	localparam logic [2:0] REG_LCR = 3'h3;
	localparam logic [2:0] REG_MCR = 3'h4;
	localparam logic [2:0] REG_LSR = 3'h5;
	localparam logic [2:0] REG_MSR = 3'h6;
	localparam logic [2:0] REG_SPR = 3'h7;

	// Field positions
	localparam int MCR_IRQ_EN_BIT = 3;
	localparam int MCR_ANY_RESUME_BIT = 5;
	localparam int MCR_PRESCALE_BIT = 7;
	localparam int FCR_RX_CLR_BIT = 1;
	localparam int FCR_TX_CLR_BIT = 2;

	// Reset values
	localparam logic [7:0] IER_RESET = 8'h00;
	localparam logic [7:0] FCR_RESET = 8'h00;
	localparam logic [7:0] LCR_RESET = 8'h00;
	localparam logic [7:0] MCR_RESET = 8'h00;
	localparam logic [7:0] SPR_RESET = 8'h00;
	localparam logic [7:0] MSR_READ = 8'h00;

	// Channel select codes
	localparam logic [3:0] SEL_NONE = 4'h0;
	localparam logic [3:0] SEL_ONE = 4'h1;

	// Reset pulse qualification timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESET_MIN_NS = 40;
	localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W = 3;
	localparam logic [2:0] RESET_MIN_COUNT = 3'(RESET_MIN_CYCLES);

	// Host bus access states
	typedef enum logic [1:0] {
		UQS_BUS_IDLE = 2'b00,
		UQS_BUS_READ = 2'b01,
		UQS_BUS_WRITE = 2'b10
	} uqs_bus_state_t;

endpackage : uqs_pkg

// >>> hdl/uqs_fifo.sv
`timescale 1ns/1ps
module uqs_fifo
	import uqs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic push,
	input wire logic [7:0] push_data,
	input wire logic pop,
	output logic [7:0] head,
	output logic empty,
	output logic full
);

	typedef struct packed {
		logic [4:0] wr_ptr;
		logic [4:0] rd_ptr;
		logic [5:0] count;
		logic empty;
		logic full;
		logic [7:0] head;
	} uqs_fifo_state_t;

	uqs_fifo_state_t st; // Registered pointers and flags
	uqs_fifo_state_t next_st; // Their next value
	logic [7:0] mem [FIFO_DEPTH]; // Storage words
	logic do_push; // Accepted write
	logic do_pop; // Accepted read

	// Pointer and flag update; head is looked up ahead so it is always current
	always_comb
	begin
		next_st = st;
		do_pop = pop && !st.empty;
		do_push = push && !st.full; // Push into a full FIFO is dropped
		if (do_push)
			next_st.wr_ptr = st.wr_ptr + 5'h01;
		if (do_pop)
			next_st.rd_ptr = st.rd_ptr + 5'h01;
		next_st.count = st.count + {5'h00, do_push} - {5'h00, do_pop};
		next_st.empty = (next_st.count == 6'h00);
		next_st.full = (next_st.count == FIFO_FULL_COUNT);
		// Forward a word written this cycle into the slot about to be read
		if (do_push && (st.wr_ptr == next_st.rd_ptr))
			next_st.head = push_data;
		else
			next_st.head = mem[next_st.rd_ptr];
		if (clear)
		begin
			next_st = '0;
			next_st.empty = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.empty <= 1'b1;
		end
		else
			st <= next_st;
	end

	// Storage write port; contents need no reset
	always_ff @(posedge clk)
	begin
		if (do_push && !clear)
			mem[st.wr_ptr] <= push_data;
	end

	assign head = st.head;
	assign empty = st.empty;
	assign full = st.full;

	a_full_holds_depth: assert property (@(posedge clk) disable iff (!rst_n)
		(st.full && push && !pop && !clear) |=> (st.count == FIFO_FULL_COUNT))
		else $error("FIFO count moved past its depth");

endmodule : uqs_fifo

// >>> hdl/uqs_reset_qual.sv
`timescale 1ns/1ps
module uqs_reset_qual
	import uqs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic active,
	output logic held
);

	typedef struct packed {
		logic [2:0] cnt;
		logic held;
	} uqs_qual_state_t;

	uqs_qual_state_t st; // Run length and qualified flag
	uqs_qual_state_t next_st; // Their next value

	// Short glitches never reach the channels; only a long enough run counts
	always_comb
	begin
		next_st = st;
		if (active)
		begin
			if (st.cnt != RESET_MIN_COUNT)
				next_st.cnt = st.cnt + 3'h1;
			next_st.held = (next_st.cnt == RESET_MIN_COUNT);
		end
		else
			next_st = '0;
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign held = st.held;

	a_short_pulse_ignored: assert property (@(posedge clk) disable iff (!rst_n)
		(!active ##1 active [*3]) |=> !held)
		else $error("Short reset pulse was taken");

endmodule : uqs_reset_qual

// >>> hdl/uqs_host_port.sv
`timescale 1ns/1ps
module uqs_host_port
	import uqs_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic bus_style_select, // High: separate strobes
	input wire logic chan_a_select_n,
	input wire logic chan_b_select_n,
	input wire logic chan_c_select_n,
	input wire logic chan_d_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic chip_select_n, // Single select style
	input wire logic read_write_n, // High: read
	input wire logic chan_addr_hi,
	input wire logic chan_addr_lo,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	input wire logic reset_in,
	input wire logic prescaler_default_select,
	input wire logic irq_style_select,
	input wire logic [3:0] chan_irq_req,
	output logic [3:0] irq_out,
	output logic [3:0] irq_oe,
	output logic serial_reset,
	output logic [3:0] prescale_div4,
	input wire logic [3:0] tx_pop,
	output logic [3:0][7:0] tx_data,
	output logic [3:0] tx_fifo_empty,
	input wire logic [3:0] rx_push,
	input wire logic [3:0][7:0] rx_data_in,
	output logic [3:0] rx_fifo_full,
	input wire logic [3:0] rx_char_seen,
	input wire logic [3:0] xon_seen,
	input wire logic [3:0] xoff_seen,
	output logic [3:0] tx_flow_paused
);

	typedef struct packed {
		uqs_bus_state_t bus;
		logic [1:0] rd_ch;
		logic [2:0] addr;
		logic [7:0] rd_data;
		logic rd_oe;
		logic [3:0][7:0] ier;
		logic [3:0][7:0] fcr;
		logic [3:0][7:0] lcr;
		logic [3:0][7:0] modem_control_reg;
		logic [3:0][7:0] spr;
		logic [3:0] paused;
		logic [3:0] irq;
		logic [3:0] irq_oe;
		logic [3:0] tx_push;
		logic [3:0] rx_pop;
		logic [3:0] tx_clr;
		logic [3:0] rx_clr;
		logic [7:0] wdata;
		logic psel_pending;
	} uqs_state_t;

	uqs_state_t st; // All registered state
	uqs_state_t next_st; // Its next value
	logic [3:0] dec_sel; // Channels addressed this cycle
	logic rd_act; // Read strobe active on a selected channel
	logic wr_act; // Write strobe active on a selected channel
	logic [1:0] rd_ch; // Channel whose data go out on a read
	logic rst_active; // Reset input at its active level
	logic chan_rst; // Qualified channel reset
	logic [3:0][7:0] rx_head; // Receive FIFO heads
	logic [3:0] rx_empty; // Receive FIFO empty flags
	logic [3:0] tx_full; // Transmit FIFO full flags

	// Reset polarity follows the bus style
	assign rst_active = bus_style_select ? reset_in : !reset_in;

	uqs_reset_qual u_reset_qual (
		.clk(mclk),
		.rst_n(rst_n),
		.active(rst_active),
		.held(chan_rst)
	);

	// Two FIFOs behind every channel's data location
	for (genvar g = 0; g < NUM_CH; g++)
	begin : g_chan
		uqs_fifo u_tx_fifo (
			.clk(mclk),
			.rst_n(rst_n),
			.clear(chan_rst || st.tx_clr[g]),
			.push(st.tx_push[g]),
			.push_data(st.wdata),
			.pop(tx_pop[g]),
			.head(tx_data[g]),
			.empty(tx_fifo_empty[g]),
			.full(tx_full[g])
		);
		uqs_fifo u_rx_fifo (
			.clk(mclk),
			.rst_n(rst_n),
			.clear(chan_rst || st.rx_clr[g]),
			.push(rx_push[g]),
			.push_data(rx_data_in[g]),
			.pop(st.rx_pop[g]),
			.head(rx_head[g]),
			.empty(rx_empty[g]),
			.full(rx_fifo_full[g])
		);
	end

	// Channel decode for both bus styles
	always_comb
	begin
		dec_sel = SEL_NONE;
		rd_act = 1'b0;
		wr_act = 1'b0;
		if (bus_style_select)
		begin
			// Channel address bits play no part here
			dec_sel = ~{chan_d_select_n, chan_c_select_n, chan_b_select_n,
				chan_a_select_n};
			rd_act = (dec_sel != SEL_NONE) && !read_strobe_n;
			wr_act = (dec_sel != SEL_NONE) && !write_strobe_n && read_strobe_n;
		end
		else if (!chip_select_n)
		begin
			dec_sel = SEL_ONE << {chan_addr_hi, chan_addr_lo};
			rd_act = read_write_n;
			wr_act = !read_write_n;
		end
		// Lowest selected channel answers a read; a read with all four
		// selected is the host's fault and just returns channel A
		rd_ch = 2'h0;
		for (int i = NUM_CH - 1; i >= 0; i--)
		begin
			if (dec_sel[i])
				rd_ch = 2'(i);
		end
	end

	// Bus sequencing, register file and channel side effects
	always_comb
	begin
		next_st = st;
		next_st.tx_push = 4'h0;
		next_st.rx_pop = 4'h0;
		next_st.tx_clr = 4'h0;
		next_st.rx_clr = 4'h0;
		// Cycles start and end on strobe levels only; no baud clock is involved
		unique case (st.bus)
			UQS_BUS_IDLE:
			begin
				if (rd_act)
				begin
					next_st.bus = UQS_BUS_READ;
					next_st.rd_ch = rd_ch;
					next_st.addr = reg_addr;
					next_st.rd_oe = 1'b1;
					// One shared data bus, data picked from the chosen set
					case (reg_addr)
						REG_DATA: next_st.rd_data = rx_head[rd_ch];
						REG_IER: next_st.rd_data = st.ier[rd_ch];
						REG_FCR_ISR: next_st.rd_data = {7'h00, !st.irq[rd_ch]};
						REG_LCR: next_st.rd_data = st.lcr[rd_ch];
						REG_MCR: next_st.rd_data = st.modem_control_reg[rd_ch];
						REG_LSR: next_st.rd_data = {1'b0, tx_fifo_empty[rd_ch],
							!tx_full[rd_ch], 4'h0, !rx_empty[rd_ch]};
						REG_MSR: next_st.rd_data = MSR_READ;
						default: next_st.rd_data = st.spr[rd_ch];
					endcase
				end
				else if (wr_act)
				begin
					next_st.bus = UQS_BUS_WRITE;
					next_st.wdata = data_in;
					// Every selected channel takes the write, so a broadcast works
					for (int i = 0; i < NUM_CH; i++)
					begin
						if (dec_sel[i])
						begin
							case (reg_addr)
								REG_DATA: next_st.tx_push[i] = 1'b1;
								REG_IER: next_st.ier[i] = data_in;
								REG_FCR_ISR:
								begin
									next_st.fcr[i] = data_in;
									next_st.tx_clr[i] = data_in[FCR_TX_CLR_BIT];
									next_st.rx_clr[i] = data_in[FCR_RX_CLR_BIT];
								end
								REG_LCR: next_st.lcr[i] = data_in;
								REG_MCR: next_st.modem_control_reg[i] = data_in;
								REG_SPR: next_st.spr[i] = data_in;
								default: ; // Status locations are read only
							endcase
						end
					end
				end
			end
			UQS_BUS_READ:
			begin
				if (!rd_act)
				begin
					// Pop at the end so the byte stays stable on the bus
					next_st.bus = UQS_BUS_IDLE;
					next_st.rd_oe = 1'b0;
					if (st.addr == REG_DATA)
						next_st.rx_pop[st.rd_ch] = !rx_empty[st.rd_ch];
				end
			end
			UQS_BUS_WRITE:
			begin
				if (!wr_act)
					next_st.bus = UQS_BUS_IDLE;
			end
			default:
			begin
				next_st.bus = UQS_BUS_IDLE;
				next_st.rd_oe = 1'b0;
			end
		endcase
		for (int i = 0; i < NUM_CH; i++)
		begin
			// Xoff sets, so it wins over a resume in the same cycle
			if (xoff_seen[i])
				next_st.paused[i] = 1'b1;
			else if (xon_seen[i] || (st.modem_control_reg[i][MCR_ANY_RESUME_BIT] && rx_char_seen[i]))
				next_st.paused[i] = 1'b0;
			next_st.irq[i] = chan_irq_req[i];
			// Continuous drive, or drive gated by the control bit
			if (bus_style_select && !irq_style_select)
				next_st.irq_oe[i] = st.modem_control_reg[i][MCR_IRQ_EN_BIT];
			else
				next_st.irq_oe[i] = 1'b1;
			// Pin sampled once, right after a reset ends
			if (st.psel_pending)
				next_st.modem_control_reg[i][MCR_PRESCALE_BIT] = !prescaler_default_select;
		end
		next_st.psel_pending = 1'b0;
		if (chan_rst)
		begin
			// Channel state returns to defaults except irq_oe, which keeps its value; bus cycle dropped
			next_st = '0;
			next_st.ier = {NUM_CH{IER_RESET}};
			next_st.fcr = {NUM_CH{FCR_RESET}};
			next_st.lcr = {NUM_CH{LCR_RESET}};
			next_st.modem_control_reg = {NUM_CH{MCR_RESET}};
			next_st.spr = {NUM_CH{SPR_RESET}};
			next_st.irq_oe = st.irq_oe;
			next_st.psel_pending = 1'b1;
		end
	end

	// State register; the pending flag makes the prescale pin load after release
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.psel_pending <= 1'b1;
		end
		else
			st <= next_st;
	end

	// Outputs straight from state
	assign data_out = st.rd_data;
	assign data_oe = st.rd_oe;
	assign irq_out = st.irq;
	assign irq_oe = st.irq_oe;
	assign serial_reset = chan_rst;
	assign tx_flow_paused = st.paused;
	for (genvar g = 0; g < NUM_CH; g++)
	begin : g_div
		assign prescale_div4[g] = st.modem_control_reg[g][MCR_PRESCALE_BIT];
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	a_single_chan_write: assert property ((st.bus == UQS_BUS_IDLE) && wr_act
		&& !chan_rst && bus_style_select && (dec_sel == 4'h2) && (reg_addr == REG_SPR)
		|=> (st.spr[1] == $past(data_in)) && (st.spr[0] == $past(st.spr[0])))
		else $error("Single select write reached wrong channel");
	a_broadcast_write: assert property ((st.bus == UQS_BUS_IDLE) && wr_act
		&& !chan_rst && bus_style_select && (dec_sel == 4'hf) && (reg_addr == REG_SPR)
		|=> (st.spr == {4{$past(data_in)}}))
		else $error("Broadcast write missed a channel");
	a_addr_bits_decode: assert property ((st.bus == UQS_BUS_IDLE) && !chan_rst
		&& !bus_style_select && !chip_select_n && !read_write_n && chan_addr_hi
		&& !chan_addr_lo && (reg_addr == REG_LCR)
		|=> (st.lcr[2] == $past(data_in)) && (st.lcr[3] == $past(st.lcr[3])))
		else $error("Channel address bits decoded wrongly");
	a_addr_bits_ignored: assert property ((st.bus == UQS_BUS_IDLE) && chan_addr_lo
		&& !chan_rst && bus_style_select && !read_strobe_n && (dec_sel == 4'h4)
		&& (reg_addr == REG_SPR) |=> (st.rd_data == $past(st.spr[2])) && st.rd_oe)
		else $error("Read data not from selected channel");
	a_read_drive: assert property ($rose(st.rd_oe) |-> $past(rd_act) ##1 (st.rd_oe || !$past(rd_act)))
		else $error("Data driven without a read");
	a_read_release: assert property ((st.bus == UQS_BUS_READ) && !rd_act
		|=> !st.rd_oe && (st.bus == UQS_BUS_IDLE))
		else $error("Data bus still driven after read");
	a_long_reset_taken: assert property (rst_active [*4] |=> chan_rst)
		else $error("Qualified reset pulse not taken");
	a_prescale_sample: assert property (st.psel_pending && !chan_rst
		|=> (prescale_div4 == {4{!$past(prescaler_default_select)}}))
		else $error("Prescale default not loaded from pin");
	a_any_char_resume: assert property (st.paused[0] && st.modem_control_reg[0][MCR_ANY_RESUME_BIT]
		&& rx_char_seen[0] && !xoff_seen[0] |=> !st.paused[0])
		else $error("Received character did not resume transmit");
	a_irq_gated: assert property (bus_style_select && !irq_style_select
		&& !chan_rst |=> (st.irq_oe[0] == $past(st.modem_control_reg[0][MCR_IRQ_EN_BIT])))
		else $error("Interrupt drive not following control bit");
	a_irq_continuous: assert property (bus_style_select && irq_style_select
		&& !chan_rst |=> (irq_oe == 4'hf))
		else $error("Continuous interrupt drive lost");

endmodule : uqs_host_port

// >>> dv/uqs_host_model.sv
`timescale 1ns/1ps
// Host processor on the 8-bit parallel bus; drives at the falling edge
module uqs_host_model
	import uqs_pkg::*;
(
	input wire logic mclk,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	output logic bus_style_select,
	output logic chan_a_select_n,
	output logic chan_b_select_n,
	output logic chan_c_select_n,
	output logic chan_d_select_n,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic chip_select_n,
	output logic read_write_n,
	output logic chan_addr_hi,
	output logic chan_addr_lo,
	output logic [2:0] reg_addr,
	output logic [7:0] data_in
);

	// Idle bus at time zero
	initial
	begin
		bus_style_select = 1'h1;
		{chan_d_select_n, chan_c_select_n, chan_b_select_n, chan_a_select_n} = 4'hf;
		{read_strobe_n, write_strobe_n, chip_select_n, read_write_n} = 4'hf;
		{chan_addr_hi, chan_addr_lo} = 2'h0;
		reg_addr = 3'h0;
		data_in = 8'h00;
	end

	// One access; sel is an active-high select mask (style 1), chan the channel (style 0)
	task automatic access(input logic style, input logic [3:0] sel, input logic [1:0] chan,
		input logic wr, input logic [2:0] addr, input logic [7:0] wdata, output logic [7:0] rd);
		rd = 8'hxx;
		@(negedge mclk);
		bus_style_select = style;
		// Channel bits also driven in style 1 as noise
		{chan_addr_hi, chan_addr_lo} = chan;
		reg_addr = addr;
		// Undriven bus shows its leftover value inverted, which after a write is the written byte again
		data_in = wr ? wdata : ~data_in;
		if (style)
		begin
			// Callers never pass all four selects on a read
			{chan_d_select_n, chan_c_select_n, chan_b_select_n, chan_a_select_n} = ~sel;
			read_strobe_n = wr;
			write_strobe_n = !wr;
		end
		else
		begin
			chip_select_n = 1'h0;
			read_write_n = !wr;
		end
		// Hold until the answer is sampled; writes take one edge
		for (int n = 0; n < 4; n++)
		begin
			@(posedge mclk);
			if (wr || data_oe === 1'h1)
			begin
				if (!wr)
					rd = data_out;
				break;
			end
		end
		@(negedge mclk);
		{chan_d_select_n, chan_c_select_n, chan_b_select_n, chan_a_select_n} = 4'hf;
		{read_strobe_n, write_strobe_n, chip_select_n, read_write_n} = 4'hf;
		data_in = ~data_in;
		// Gap lets a data read pop and look up the next head
		repeat (3) @(negedge mclk);
	endtask : access

endmodule : uqs_host_model

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench
	import uqs_pkg::*;
;
	// One compare: counts it, reports a mismatch
	`define CHK(what, exp, got) \
		begin \
			check_count++; \
			if ((got) !== (exp)) \
			begin \
				failures++; \
				$display("[ERR] %s expected %h seen %h", what, exp, got); \
			end \
		end

	typedef struct packed {
		logic style;
		logic [3:0] sel;
		logic [1:0] chan;
		logic wr;
		logic [2:0] addr;
		logic [7:0] data;
	} uqs_row_t;

	int failures = 0;
	int check_count = 0;
	logic mclk = 1'h0;
	logic rst_n = 1'h0;
	logic rst_chan = 1'h0; // Channel reset request, active high
	int reset_cycles = 0; // Edges seen with serial reset high
	int reset_base = 0; // Count taken when a pulse test starts
	logic pds = 1'h1;
	logic iss = 1'h0;
	logic [3:0] chan_irq_req = 4'h0;
	logic [3:0] tx_pop = 4'h0;
	logic [3:0] rx_push = 4'h0;
	logic [3:0][7:0] rx_data_in = '0;
	logic [3:0] rx_char_seen = 4'h0;
	logic [3:0] xon_seen = 4'h0;
	logic [3:0] xoff_seen = 4'h0;
	logic [7:0] rd;
	wire logic bss, csa_n, csb_n, csc_n, csd_n, rds_n, wrs_n, cs_n, rw_n, ahi, alo, data_oe;
	wire logic serial_reset;
	wire logic [2:0] reg_addr;
	wire logic [7:0] data_in, data_out;
	wire logic [3:0] irq_out, irq_oe, prescale_div4, tx_fifo_empty, rx_fifo_full, paused;
	wire logic [3:0][7:0] tx_data;
	// Reset pin polarity follows the bus style
	wire logic reset_in = bss ? rst_chan : ~rst_chan;

	// Plain cases: write, then read back through either style
	uqs_row_t rows [0:12] = '{
		{1'h1, 4'hf, 2'h0, 1'h1, 3'h7, 8'h55}, {1'h1, 4'h1, 2'h3, 1'h0, 3'h7, 8'h55},
		{1'h1, 4'h8, 2'h0, 1'h0, 3'h7, 8'h55}, {1'h1, 4'h2, 2'h0, 1'h1, 3'h7, 8'ha1},
		{1'h1, 4'h4, 2'h1, 1'h0, 3'h7, 8'h55}, {1'h0, 4'h0, 2'h1, 1'h0, 3'h7, 8'ha1},
		{1'h0, 4'h0, 2'h2, 1'h1, 3'h3, 8'h3c}, {1'h1, 4'h4, 2'h0, 1'h0, 3'h3, 8'h3c},
		{1'h0, 4'h0, 2'h3, 1'h0, 3'h3, 8'h00}, {1'h1, 4'h1, 2'h0, 1'h0, 3'h6, 8'h00},
		{1'h1, 4'h2, 2'h0, 1'h0, 3'h2, 8'h01}, {1'h0, 4'h0, 2'h3, 1'h1, 3'h1, 8'h5a},
		{1'h1, 4'h8, 2'h0, 1'h0, 3'h1, 8'h5a}
	};

	initial
	begin
		forever #5 mclk = ~mclk;
	end

	// Serial reset edges counted only here; the sequence takes differences
	always @(posedge mclk)
	begin
		if (serial_reset === 1'h1)
			reset_cycles <= reset_cycles + 1;
	end

	uqs_host_model host (.mclk(mclk), .data_out(data_out), .data_oe(data_oe),
		.bus_style_select(bss), .chan_a_select_n(csa_n), .chan_b_select_n(csb_n),
		.chan_c_select_n(csc_n), .chan_d_select_n(csd_n), .read_strobe_n(rds_n),
		.write_strobe_n(wrs_n), .chip_select_n(cs_n), .read_write_n(rw_n),
		.chan_addr_hi(ahi), .chan_addr_lo(alo), .reg_addr(reg_addr), .data_in(data_in));

	uqs_host_port dut (.mclk(mclk), .rst_n(rst_n), .bus_style_select(bss),
		.chan_a_select_n(csa_n), .chan_b_select_n(csb_n), .chan_c_select_n(csc_n),
		.chan_d_select_n(csd_n), .read_strobe_n(rds_n), .write_strobe_n(wrs_n),
		.chip_select_n(cs_n), .read_write_n(rw_n), .chan_addr_hi(ahi), .chan_addr_lo(alo),
		.reg_addr(reg_addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.reset_in(reset_in), .prescaler_default_select(pds), .irq_style_select(iss),
		.chan_irq_req(chan_irq_req), .irq_out(irq_out), .irq_oe(irq_oe),
		.serial_reset(serial_reset), .prescale_div4(prescale_div4), .tx_pop(tx_pop),
		.tx_data(tx_data), .tx_fifo_empty(tx_fifo_empty), .rx_push(rx_push),
		.rx_data_in(rx_data_in), .rx_fifo_full(rx_fifo_full), .rx_char_seen(rx_char_seen),
		.xon_seen(xon_seen), .xoff_seen(xoff_seen), .tx_flow_paused(paused));

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	// Hang guard, well past the expected run
	initial
	begin
		repeat (20000) @(posedge mclk);
		failures++;
		final_report();
	end

	initial
	begin
		repeat (3) @(negedge mclk);
		rst_n = 1'h1;
		repeat (2) @(negedge mclk);
		`CHK("div4 after reset", 4'h0, prescale_div4)
		`CHK("tx empty after reset", 4'hf, tx_fifo_empty)
		`CHK("paused after reset", 4'h0, paused)
		foreach (rows[i])
		begin
			host.access(rows[i].style, rows[i].sel, rows[i].chan, rows[i].wr,
				rows[i].addr, rows[i].data, rd);
			if (!rows[i].wr)
				`CHK("row read", rows[i].data, rd)
		end
		// Pin moves after reset: only the control bit may change the divider
		pds = 1'h0;
		host.access(1'h1, 4'h1, 2'h0, 1'h1, REG_MCR, 8'ha8, rd);
		`CHK("div4 override", 4'h1, prescale_div4)
		`CHK("irq gated", 4'h1, irq_oe)
		iss = 1'h1;
		chan_irq_req = 4'h5;
		repeat (2) @(negedge mclk);
		`CHK("irq continuous", 4'hf, irq_oe)
		`CHK("irq copy", 4'h5, irq_out)
		// Flow: any character resumes only where the control bit is set
		xoff_seen = 4'h3;
		@(negedge mclk) xoff_seen = 4'h0;
		rx_char_seen = 4'h3;
		@(negedge mclk) rx_char_seen = 4'h0;
		@(negedge mclk);
		`CHK("any char resume", 4'h2, paused)
		// Transmit queue: one byte past capacity is dropped
		for (int i = 0; i <= FIFO_DEPTH; i++)
			host.access(1'h1, 4'h4, 2'h0, 1'h1, REG_DATA, 8'(i), rd);
		for (int i = 0; i < FIFO_DEPTH; i++)
		begin
			`CHK("tx head", 8'(i), tx_data[2])
			tx_pop = 4'h4;
			@(negedge mclk) tx_pop = 4'h0;
			@(negedge mclk);
		end
		`CHK("tx drained", 1'h1, tx_fifo_empty[2])
		// Receive queue filled past capacity; push held high, one byte per edge
		rx_push = 4'h8;
		for (int i = 0; i <= FIFO_DEPTH; i++)
		begin
			rx_data_in[3] = 8'h40 + 8'(i);
			@(negedge mclk);
		end
		rx_push = 4'h0;
		`CHK("rx full", 1'h1, rx_fifo_full[3])
		host.access(1'h1, 4'h8, 2'h0, 1'h0, REG_DATA, 8'h00, rd);
		`CHK("rx first", 8'h40, rd)
		`CHK("oe released", 1'h0, data_oe)
		host.access(1'h0, 4'h0, 2'h3, 1'h0, REG_DATA, 8'h00, rd);
		`CHK("rx second", 8'h41, rd)
		// Status before and after a flush of both queues
		host.access(1'h1, 4'h8, 2'h0, 1'h0, REG_LSR, 8'h00, rd);
		`CHK("lsr before flush", 8'h61, rd)
		host.access(1'h1, 4'h8, 2'h0, 1'h1, REG_FCR_ISR, 8'h06, rd);
		host.access(1'h1, 4'h8, 2'h0, 1'h0, REG_LSR, 8'h00, rd);
		`CHK("lsr after flush", 8'h60, rd)
		// Channel reset: 3 cycles too short, 6 cycles acts
		reset_base = reset_cycles;
		rst_chan = 1'h1;
		repeat (3) @(negedge mclk);
		rst_chan = 1'h0;
		host.access(1'h1, 4'h1, 2'h0, 1'h0, REG_SPR, 8'h00, rd);
		`CHK("short pulse", 0, reset_cycles - reset_base)
		`CHK("short keeps", 8'h55, rd)
		reset_base = reset_cycles;
		rst_chan = 1'h1;
		repeat (6) @(negedge mclk);
		rst_chan = 1'h0;
		host.access(1'h1, 4'h1, 2'h0, 1'h0, REG_SPR, 8'h00, rd);
		`CHK("long pulse", 6 - RESET_MIN_CYCLES + 1, reset_cycles - reset_base)
		`CHK("long clears", 8'h00, rd)
		`CHK("div4 resampled", 4'hf, prescale_div4)
		// Single-select style: reset pin active low
		host.access(1'h0, 4'h0, 2'h0, 1'h1, REG_SPR, 8'h77, rd);
		reset_base = reset_cycles;
		rst_chan = 1'h1;
		repeat (5) @(negedge mclk);
		rst_chan = 1'h0;
		host.access(1'h0, 4'h0, 2'h0, 1'h0, REG_SPR, 8'h00, rd);
		`CHK("low reset", 5 - RESET_MIN_CYCLES + 1, reset_cycles - reset_base)
		`CHK("low reset clears", 8'h00, rd)
		final_report();
	end

endmodule : testbench
